// File: design/rcc_pkg.sv
// rcc_pkg: register map, field positions, reset values and timing
// constants shared by the clock-calendar control block and its helpers.
// assumes a 20 MHz system clock and a 32.768 kHz timebase tick input.
package rcc_pkg;

  // ==========================================================
  // clocking
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  // timebase considered stopped when no tick for this long
  localparam int unsigned RUN_TIMEOUT_NS = 100_000;
  localparam int unsigned RUN_TIMEOUT_CYC = RUN_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int unsigned PRESC_W = 15;
  // ticks before a second rollover during which reads are unsafe
  localparam int unsigned SYNC_WINDOW = 32;

  // ==========================================================
  // register offsets (byte addresses) and alias operations
  localparam logic [11:0] OFS_CTRL = 12'h200;
  localparam logic [11:0] OFS_ALRM = 12'h210;
  localparam logic [11:0] OFS_TIME = 12'h220;
  localparam logic [11:0] OFS_DATE = 12'h230;
  localparam logic [11:0] OFS_ATIME = 12'h240;
  localparam logic [11:0] OFS_ADATE = 12'h250;
  typedef enum logic [1:0] {
    OP_WR = 2'h0,
    OP_CLR = 2'h1,
    OP_SET = 2'h2,
    OP_INV = 2'h3
  } rcc_op_t;

  // ==========================================================
  // control, alarm-control and time register fields
  localparam int unsigned CAL_LSB = 16;
  localparam int unsigned CAL_W = 10;
  localparam int unsigned BIT_ON = 15;
  localparam int unsigned BIT_STOP_IN_IDLE = 13;
  localparam int unsigned BIT_OSEL = 7;
  localparam int unsigned BIT_RUN = 6;
  localparam int unsigned BIT_WREN = 3;
  localparam int unsigned BIT_SYNC = 2;
  localparam int unsigned BIT_HALF = 1;
  localparam int unsigned BIT_OE = 0;
  localparam int unsigned BIT_PIV = 13;
  localparam int unsigned BIT_ASYNC = 12;
  localparam int unsigned SEC_LSB = 8;
  localparam int unsigned MIN_LSB = 16;
  localparam int unsigned HR_LSB = 24;
  localparam logic [6:0] SEC_MAX = 7'h59;
  localparam logic [6:0] HR_MAX = 7'h23;

  // ==========================================================
  // writable masks and reset values
  localparam logic [31:0] CTRL_WMASK = 32'h03ff_a089;
  localparam logic [31:0] ALRM_WMASK = 32'h0000_efff;
  localparam logic [31:0] TIME_WMASK = 32'h3f7f_7f00;
  localparam logic [31:0] DATE_WMASK = 32'hff1f_3f07;
  localparam logic [31:0] ADATE_WMASK = 32'h001f_ff07;
  localparam logic [31:0] SEC_MASK = 32'h0000_7f00;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ALRM_RST = 32'h0000_0000;
  localparam logic [31:0] VALUE_RST = 32'h0000_0000;

  // one register access handed from the bus slave to the register bank
  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } rcc_req_t;

endpackage

// File: design/rcc_timebase.sv
// rcc_timebase: seconds prescaler on the 32.768 kHz tick with per-minute
// drift correction. assumes tick is a one-cycle pulse synchronous to clk.
`timescale 1ns/1ps
module rcc_timebase
  import rcc_pkg::*;
#(
  parameter int unsigned CW = CAL_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic tick,
  input wire logic [CW-1:0] cal,
  input wire logic minute_start,
  input wire logic restart,
  output logic sec_pulse,
  output logic half_sec,
  output logic read_unsafe,
  output logic sec_clk
);
  logic [PRESC_W-1:0] presc_q, presc_d;
  logic signed [CW:0] adj_q, adj_d;
  logic sec_q, sec_d, unsafe_q, unsafe_d;
  logic [PRESC_W:0] sum;
  logic [1:0] step;

  // ==========================================================
  // prescaler: extra or dropped pulses spread over the next ticks
  always_comb begin
    presc_d = presc_q;
    adj_d = adj_q;
    sec_d = 1'b0;
    step = 2'h1;
    sum = '0;
    if (adj_q > 0) begin
      step = 2'h2; // inserted pulse [RULE1]
    end else if (adj_q < 0) begin
      step = 2'h0; // removed pulse [RULE2]
    end
    if (restart) begin
      presc_d = '0;
    end else if (run && tick) begin
      sum = {1'b0, presc_q} + {{(PRESC_W - 1){1'b0}}, step};
      presc_d = sum[PRESC_W-1:0];
      sec_d = sum[PRESC_W];
      if (adj_q > 0) begin
        adj_d = adj_q - 1'b1;
      end else if (adj_q < 0) begin
        adj_d = adj_q + 1'b1;
      end
    end
    // reload once a minute, on the timebase, leaving the count alone
    if (minute_start) begin
      adj_d = {cal[CW-1], cal}; // [RULE19]
    end
    unsafe_d = (presc_d >= PRESC_W'((1 << PRESC_W) - SYNC_WINDOW)); // [RULE16]
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      presc_q <= '0;
      adj_q <= '0;
      sec_q <= 1'b0;
      unsafe_q <= 1'b0;
    end else begin
      presc_q <= presc_d;
      adj_q <= adj_d;
      sec_q <= sec_d;
      unsafe_q <= unsafe_d;
    end
  end

  assign sec_pulse = sec_q;
  assign half_sec = presc_q[PRESC_W-1]; // [RULE17]
  assign sec_clk = ~presc_q[PRESC_W-1];
  assign read_unsafe = unsafe_q;
endmodule // rcc_timebase

// File: design/rcc_ahb_slv.sv
// rcc_ahb_slv: AHB-Lite slave front end; zero-wait writes, one wait on
// reads. assumes single word transfers and a single slave on the bus.
`timescale 1ns/1ps
module rcc_ahb_slv
  import rcc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output rcc_req_t req,
  input wire logic [31:0] rdata
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_WR = 4'b0010,
    S_RD = 4'b0100,
    S_RDY = 4'b1000
  } rcc_bus_st_t;
  rcc_bus_st_t st_q, st_d;
  logic [11:0] addr_q, addr_d;
  logic [31:0] rd_q, rd_d;
  logic accept;

  // ==========================================================
  // address phase capture; hsize is not checked, only words are used
  always_comb begin
    accept = hsel && htrans[1] && hready;
    st_d = st_q;
    addr_d = addr_q;
    rd_d = rd_q;
    unique case (st_q)
      S_RD: begin
        st_d = S_RDY;
        rd_d = rdata;
      end
      default: begin
        st_d = accept ? (hwrite ? S_WR : S_RD) : S_IDLE;
        if (accept) begin
          addr_d = haddr[11:0];
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= S_IDLE;
      addr_q <= '0;
      rd_q <= '0;
    end else begin
      st_q <= st_d;
      addr_q <= addr_d;
      rd_q <= rd_d;
    end
  end

  assign req = '{valid: (st_q == S_WR) || (st_q == S_RD), write: (st_q == S_WR),
                 addr: addr_q, wdata: hwdata};
  assign hreadyout = (st_q != S_RD);
  assign hrdata = rd_q;
  assign hresp = 1'b0;
endmodule // rcc_ahb_slv

// File: design/rcc_ctrl.sv
// rcc_ctrl: control and value registers of the clock-calendar unit,
// reached over AHB-Lite, with seconds counting and the output pin.
// assumes TIMEBASE_TICK is a one-cycle 32.768 kHz pulse on SYS_CLK and
// UNLOCK_OPEN is high while the system write-unlock sequence is open.
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps

// Function
// RULE1 - positive calibration adds N pulses per minute
// RULE2 - negative calibration removes pulses per minute
// RULE3 - module runs only while enable bit set
// RULE4 - enable bit changes only while unlock set
// RULE5 - unlock bit settable only after system unlock
// RULE6 - stop-in-idle freezes bus access in idle
// RULE7 - output select: seconds clock or alarm pulse
// RULE8 - pin shows signal only with output enable
// RULE9 - read-only status: timebase actually running
// RULE10 - seconds write clears half-second flag
// RULE11 - aliases at 4, 8, C clear/set/invert
// RULE12 - software skips access right after disabling
// RULE13 - control registers reset to zero
// RULE14 - unimplemented control bits read zero
// RULE15 - value registers writable only while unlocked
// RULE16 - read-unsafe flag near rollover ripple
// RULE17 - half-second flag high in second half
// RULE18 - output enable drives pin, else off
// RULE19 - calibration applied once per minute on timebase
module rcc_ctrl
  import rcc_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = RUN_TIMEOUT_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  input wire logic TIMEBASE_TICK,
  input wire logic SYS_IDLE,
  input wire logic UNLOCK_OPEN,
  output logic BUS_CLK_GATED,
  output logic MODULE_ON,
  output logic OUT_PIN_O,
  output logic OUT_PIN_OE
);
  rcc_req_t req;
  logic [31:0] rdata;
  logic [31:0] ctrl_q, ctrl_d, alrm_q, alrm_d;
  logic [31:0] time_q, time_d, date_q, date_d;
  logic [31:0] atime_q, atime_d, adate_q, adate_d;
  logic [15:0] run_cnt_q, run_cnt_d;
  logic running_q, running_d;
  logic gated_q, gated_d;
  logic pin_q, pin_d;
  logic wr_ok, rd_ok, on, wren;
  logic sec_pulse, half_sec, read_unsafe, sec_clk;
  logic minute_start, sec_restart;
  rcc_op_t op;
  logic [2:0] sel;
  logic [7:0] sec_step, min_step, hr_step;

  // ==========================================================
  // helpers
  // register index from a byte address, 3'h7 when unmapped
  function automatic logic [2:0] reg_index(input logic [11:0] a);
    logic [2:0] r;
    r = 3'h7;
    unique case ({a[11:4], 4'h0})
      OFS_CTRL: r = 3'h0;
      OFS_ALRM: r = 3'h1;
      OFS_TIME: r = 3'h2;
      OFS_DATE: r = 3'h3;
      OFS_ATIME: r = 3'h4;
      OFS_ADATE: r = 3'h5;
      default: r = 3'h7;
    endcase
    return r;
  endfunction

  // plain write or clear/set/invert alias, limited to writable bits
  function automatic logic [31:0] apply_op(input logic [31:0] old, input logic [31:0] wd,
                                           input rcc_op_t o, input logic [31:0] mask);
    logic [31:0] nv;
    nv = wd;
    unique case (o)
      OP_WR: nv = wd;
      OP_CLR: nv = old & ~wd; // [RULE11]
      OP_SET: nv = old | wd; // [RULE11]
      OP_INV: nv = old ^ wd; // [RULE11]
    endcase
    return (old & ~mask) | (nv & mask); // [RULE14]
  endfunction

  // bcd increment with wrap at max, carry in bit 7
  function automatic logic [7:0] bcd_step(input logic [6:0] v, input logic [6:0] max);
    logic [7:0] r;
    r = {1'b0, v + 7'h01};
    if (v == max) begin
      r = 8'h80;
    end else if (v[3:0] == 4'h9) begin
      r = {1'b0, v[6:4] + 3'h1, 4'h0};
    end
    return r;
  endfunction

  // ==========================================================
  // bus front end
  rcc_ahb_slv u_bus (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .hsel(HSEL),
    .haddr(HADDR),
    .htrans(HTRANS),
    .hwrite(HWRITE),
    .hsize(HSIZE),
    .hwdata(HWDATA),
    .hready(HREADY),
    .hreadyout(HREADYOUT),
    .hrdata(HRDATA),
    .hresp(HRESP),
    .req(req),
    .rdata(rdata)
  );

  // ==========================================================
  // timebase and seconds prescaler
  rcc_timebase #(
    .CW(CAL_W)
  ) u_tb (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .run(on),
    .tick(TIMEBASE_TICK),
    .cal(ctrl_q[CAL_LSB +: CAL_W]),
    .minute_start(minute_start),
    .restart(sec_restart),
    .sec_pulse(sec_pulse),
    .half_sec(half_sec),
    .read_unsafe(read_unsafe),
    .sec_clk(sec_clk)
  );

  // ==========================================================
  // access decode
  // a gated bus clock is modelled by ignoring writes and reading zero,
  // so the bus still completes instead of hanging the master
  always_comb begin
    on = ctrl_q[BIT_ON]; // [RULE3]
    wren = ctrl_q[BIT_WREN];
    op = rcc_op_t'(req.addr[3:2]);
    sel = reg_index(req.addr);
    wr_ok = req.valid && req.write && !gated_q; // [RULE6]
    rd_ok = req.valid && !req.write && !gated_q; // [RULE6]
  end

  // ==========================================================
  // control and alarm-control registers
  always_comb begin
    ctrl_d = ctrl_q;
    alrm_d = alrm_q;
    if (wr_ok && sel == 3'h0) begin
      ctrl_d = apply_op(ctrl_q, req.wdata, op, CTRL_WMASK);
      // unlock may always be cleared, but only set while the system
      // unlock sequence is open
      if (ctrl_d[BIT_WREN] && !wren && !UNLOCK_OPEN) begin
        ctrl_d[BIT_WREN] = 1'b0; // [RULE5]
      end
      // enable is judged against the unlock bit before this write
      if (!wren) begin
        ctrl_d[BIT_ON] = ctrl_q[BIT_ON]; // [RULE4]
      end
    end
    if (wr_ok && sel == 3'h1) begin
      alrm_d = apply_op(alrm_q, req.wdata, op, ALRM_WMASK);
    end
  end

  // ==========================================================
  // value registers: bus writes win over the seconds count
  always_comb begin
    time_d = time_q;
    date_d = date_q;
    atime_d = atime_q;
    adate_d = adate_q;
    sec_restart = 1'b0;
    minute_start = 1'b0;
    sec_step = bcd_step(time_q[SEC_LSB +: 7], SEC_MAX);
    min_step = bcd_step(time_q[MIN_LSB +: 7], SEC_MAX);
    hr_step = bcd_step({1'b0, time_q[HR_LSB +: 6]}, HR_MAX);
    if (on && sec_pulse) begin
      time_d[SEC_LSB +: 7] = sec_step[6:0];
      if (sec_step[7]) begin
        minute_start = 1'b1; // [RULE19]
        time_d[MIN_LSB +: 7] = min_step[6:0];
        if (min_step[7]) begin
          time_d[HR_LSB +: 6] = hr_step[5:0];
        end
      end
    end
    if (wr_ok && wren) begin // [RULE15]
      unique case (sel)
        3'h2: begin
          time_d = apply_op(time_q, req.wdata, op, TIME_WMASK);
          // restarting the prescaler puts the flag in the first half
          sec_restart = |(req.wdata & SEC_MASK) || op == OP_WR; // [RULE10]
        end
        3'h3: date_d = apply_op(date_q, req.wdata, op, DATE_WMASK);
        3'h4: atime_d = apply_op(atime_q, req.wdata, op, TIME_WMASK);
        3'h5: adate_d = apply_op(adate_q, req.wdata, op, ADATE_WMASK);
        default: time_d = time_d;
      endcase
    end
  end

  // ==========================================================
  // timebase running status, pin output and idle gating
  always_comb begin
    run_cnt_d = run_cnt_q;
    running_d = running_q;
    if (!on) begin
      running_d = 1'b0; // [RULE9]
      run_cnt_d = '0;
    end else if (TIMEBASE_TICK) begin
      running_d = 1'b1; // [RULE9]
      run_cnt_d = '0;
    end else if (run_cnt_q == 16'(TIMEOUT_CYC - 1)) begin
      running_d = 1'b0; // [RULE9]
    end else begin
      run_cnt_d = run_cnt_q + 16'h0001;
    end
    // alarm pulse level is the held initial value; alarm matching lives
    // outside this block
    pin_d = on && (ctrl_q[BIT_OSEL] ? sec_clk : alrm_q[BIT_PIV]); // [RULE7]
    gated_d = SYS_IDLE && ctrl_q[BIT_STOP_IN_IDLE]; // [RULE6]
  end

  // ==========================================================
  // state registers
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      ctrl_q <= CTRL_RST; // [RULE13]
      alrm_q <= ALRM_RST; // [RULE13]
      time_q <= VALUE_RST;
      date_q <= VALUE_RST;
      atime_q <= VALUE_RST;
      adate_q <= VALUE_RST;
      run_cnt_q <= '0;
      running_q <= 1'b0;
      gated_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      alrm_q <= alrm_d;
      time_q <= time_d;
      date_q <= date_d;
      atime_q <= atime_d;
      adate_q <= adate_d;
      run_cnt_q <= run_cnt_d;
      running_q <= running_d;
      gated_q <= gated_d;
      pin_q <= pin_d;
    end
  end

  // ==========================================================
  // read mux; aliases read back their base register
  always_comb begin
    rdata = 32'h0000_0000;
    if (rd_ok) begin
      unique case (sel)
        3'h0: begin
          rdata = ctrl_q & CTRL_WMASK; // [RULE14]
          rdata[BIT_RUN] = running_q; // [RULE9]
          rdata[BIT_SYNC] = read_unsafe; // [RULE16]
          rdata[BIT_HALF] = half_sec; // [RULE17]
        end
        3'h1: begin
          rdata = alrm_q;
          rdata[BIT_ASYNC] = read_unsafe;
        end
        3'h2: rdata = time_q;
        3'h3: rdata = date_q;
        3'h4: rdata = atime_q;
        3'h5: rdata = adate_q;
        default: rdata = 32'h0000_0000;
      endcase
    end
  end

  assign OUT_PIN_O = pin_q & ctrl_q[BIT_OE]; // [RULE8]
  assign OUT_PIN_OE = ctrl_q[BIT_OE]; // [RULE18]
  assign MODULE_ON = ctrl_q[BIT_ON];
  assign BUS_CLK_GATED = gated_q;
endmodule // rcc_ctrl

// File: tb/rcc_ctrl_monitor.sv
// rcc_ctrl_monitor: concurrent checks on the ports of rcc_ctrl.
// assumes the single-slave AHB-Lite hookup, HREADY tied to HREADYOUT.
`timescale 1ns/1ps
module rcc_ctrl_monitor (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic [31:0] HRDATA,
  input wire logic SYS_IDLE,
  input wire logic BUS_CLK_GATED,
  input wire logic MODULE_ON,
  input wire logic OUT_PIN_O,
  input wire logic OUT_PIN_OE
);
  // ==========================================================
  // transfer decode
  logic rd_take;
  logic wr_take;
  logic wr_dp_q;
  logic wr_dp_d;
  assign rd_take = HSEL && HTRANS[1] && HREADY && !HWRITE;
  assign wr_take = HSEL && HTRANS[1] && HREADY && HWRITE;
  // marks the write data phase cycle
  always_comb wr_dp_d = wr_take;
  always_ff @(posedge SYS_CLK) wr_dp_q <= RESET_N ? wr_dp_d : 1'b0;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  // ==========================================================
  // properties
  property p_reset_zero;
    $rose(RESET_N) |-> !MODULE_ON && !OUT_PIN_OE && !OUT_PIN_O;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("outputs not clear after reset");
  property p_gate_idle;
    !$past(SYS_IDLE) |-> !BUS_CLK_GATED;
  endproperty
  a_gate_idle: assert property (p_gate_idle) else $error("gated without idle");
  property p_gated_read;
    rd_take ##2 BUS_CLK_GATED |=> HRDATA == 32'h0;
  endproperty
  a_gated_read: assert property (p_gated_read) else $error("read while gated not zero");
  property p_unimpl;
    rd_take && HADDR[11:4] == 8'h20 |=> ##2 (HRDATA & 32'hfc00_5f30) == 32'h0;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented control bit set");
  property p_pin_oe;
    !OUT_PIN_OE && !$past(OUT_PIN_OE) |-> !OUT_PIN_O;
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("pin active without enable");
  property p_pin_on;
    !MODULE_ON && !$past(MODULE_ON) |-> !OUT_PIN_O;
  endproperty
  a_pin_on: assert property (p_pin_on) else $error("pin active while module off");
  property p_on_by_write;
    $changed(MODULE_ON) |-> $past(wr_dp_q) || $past(wr_dp_q, 2);
  endproperty
  a_on_by_write: assert property (p_on_by_write) else $error("enable moved without write");
  property p_rd_wait;
    rd_take |=> !HREADYOUT ##1 HREADYOUT;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_wr_nowait;
    wr_take |=> HREADYOUT;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");

  // main scenarios reached
  c_gated: cover property (rd_take && BUS_CLK_GATED);
  c_pin: cover property (OUT_PIN_O);
  c_on: cover property ($rose(MODULE_ON));
endmodule // rcc_ctrl_monitor

bind rcc_ctrl rcc_ctrl_monitor i_mon (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
  .HRDATA(HRDATA), .SYS_IDLE(SYS_IDLE), .BUS_CLK_GATED(BUS_CLK_GATED),
  .MODULE_ON(MODULE_ON), .OUT_PIN_O(OUT_PIN_O), .OUT_PIN_OE(OUT_PIN_OE));

// File: tb/testbench.sv
// testbench: drives rcc_ctrl over AHB-Lite against a bench model.
// assumes the package map and a short running timeout of 8 cycles.
`timescale 1ns/1ps
module testbench;
  import rcc_pkg::*;
  logic SYS_CLK, RESET_N, HSEL, HWRITE, SYS_IDLE, UNLOCK_OPEN, tick_en, pin0;
  logic TIMEBASE_TICK = 1'b0;
  logic [31:0] HADDR, HWDATA, HRDATA, rd_v, ctrl_m, rnd;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  logic HREADYOUT, HRESP, BUS_CLK_GATED, MODULE_ON, OUT_PIN_O, OUT_PIN_OE;
  logic [11:0] rs [3] = '{12'h200, 12'h210, 12'h300};
  logic [9:0] cals [4] = '{10'h1ff, 10'h200, 10'h3ff, 10'h001};
  int error_cnt = 0;
  int checks = 0;
  int tick_cnt = 0;
  int base = 0;

  rcc_ctrl #(.TIMEOUT_CYC(8)) i_dut (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP),
    .TIMEBASE_TICK(TIMEBASE_TICK), .SYS_IDLE(SYS_IDLE), .UNLOCK_OPEN(UNLOCK_OPEN),
    .BUS_CLK_GATED(BUS_CLK_GATED), .MODULE_ON(MODULE_ON), .OUT_PIN_O(OUT_PIN_O),
    .OUT_PIN_OE(OUT_PIN_OE));

  // ==========================================================
  // clock and timebase ticks, one tick every two cycles
  initial begin
    SYS_CLK = 1'b0;
    forever #25 SYS_CLK = ~SYS_CLK;
  end
  always @(posedge SYS_CLK) begin
    TIMEBASE_TICK <= tick_en & ~TIMEBASE_TICK;
    if (TIMEBASE_TICK) tick_cnt <= tick_cnt + 1;
  end

  // ==========================================================
  // reporting
  task conclude;
    $display("counts: %0d checks, %0d mismatches", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // ==========================================================
  // bus master; ready and read data taken at the rising edge, before
  // the design's flops move on
  task wait_rdy;
    int n;
    n = 0;
    @(posedge SYS_CLK);
    while (HREADYOUT !== 1'b1) begin
      n++;
      if (n > 50) begin
        error_cnt++;
        conclude();
      end
      @(posedge SYS_CLK);
    end
    rd_v = HRDATA;
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    HADDR <= {20'h0, a};
    HWRITE <= w;
    HTRANS <= 2'h2;
    wait_rdy();
    HTRANS <= 2'h0;
    HWDATA <= d;
    wait_rdy();
  endtask
  task wait_ticks(input int n);
    int k;
    k = 0;
    while (tick_cnt - base < n) begin
      @(posedge SYS_CLK);
      k++;
      if (k > 70000) begin
        error_cnt++;
        conclude();
      end
    end
  endtask

  // ==========================================================
  // control register model: mask, lock of enable, unlock gating
  function logic [31:0] ctl_next(input logic [1:0] op, input logic [31:0] d);
    logic [31:0] n;
    case (op)
      2'h0: n = d;
      2'h1: n = ctrl_m & ~d;
      2'h2: n = ctrl_m | d;
      default: n = ctrl_m ^ d;
    endcase
    n = n & CTRL_WMASK;
    if (!ctrl_m[3]) n[15] = ctrl_m[15];
    n[3] = n[3] & (UNLOCK_OPEN | ctrl_m[3]);
    return n;
  endfunction
  function logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0);
  endfunction
  task cw(input logic [1:0] op, input logic [31:0] d);
    bus(1'b1, {8'h20, op, 2'b00}, d);
    ctrl_m = ctl_next(op, d);
    @(posedge SYS_CLK); // quiet cycle after a control write
  endtask
  // status bits move with the timebase, so they are left out here
  task cchk;
    bus(1'b0, 12'h200, 32'h0);
    chk(rd_v & ~32'h46, ctrl_m & ~32'h46);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    RESET_N = 1'b0;
    HSEL = 1'b1;
    HADDR = 32'h0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
    SYS_IDLE = 1'b0;
    UNLOCK_OPEN = 1'b0;
    tick_en = 1'b0;
    ctrl_m = 32'h0;
    rnd = 32'h0001_1566; // seed 71014
    repeat (5) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    foreach (rs[i]) begin
      bus(1'b0, rs[i], 32'h0);
      chk(rd_v, 32'h0);
    end
    $display("test reset values done");
    cw(2'h0, 32'hffff_ffff);
    cchk();
    chk(32'(MODULE_ON), 32'h0);
    foreach (cals[i]) begin
      cw(2'h0, {6'h0, cals[i], 16'h0});
      cchk();
    end
    UNLOCK_OPEN <= 1'b1;
    cw(2'h2, 32'h8);
    cw(2'h2, 32'h8000);
    cchk();
    chk(32'(MODULE_ON), 32'h1);
    $display("test lock and enable done");
    UNLOCK_OPEN <= 1'b0;
    cw(2'h1, 32'h8);
    bus(1'b1, 12'h220, 32'h0012_3400);
    bus(1'b0, 12'h220, 32'h0);
    chk(rd_v, 32'h0);
    UNLOCK_OPEN <= 1'b1;
    cw(2'h2, 32'h8);
    bus(1'b1, 12'h220, 32'h0012_3400);
    bus(1'b0, 12'h220, 32'h0);
    chk(rd_v, 32'h0012_3400);
    // random aliases; the bus gap after a disable keeps software quiet
    repeat (16) begin
      rnd = lfsr(rnd);
      UNLOCK_OPEN <= rnd[0];
      cw(rnd[2:1], rnd);
      cchk();
    end
    UNLOCK_OPEN <= 1'b1;
    cw(2'h2, 32'h8);
    cw(2'h0, 32'h0000_8009);
    cchk();
    $display("test aliases done");
    bus(1'b1, 12'h210, 32'h2000);
    bus(1'b0, 12'h210, 32'h0);
    chk(rd_v, 32'h2000);
    repeat (3) @(negedge SYS_CLK);
    chk(32'(OUT_PIN_O), 32'h1);
    chk(32'(OUT_PIN_OE), 32'h1);
    @(posedge SYS_CLK);
    cw(2'h1, 32'h1);
    repeat (3) @(negedge SYS_CLK);
    chk(32'(OUT_PIN_O), 32'h0);
    chk(32'(OUT_PIN_OE), 32'h0);
    @(posedge SYS_CLK);
    $display("test pin done");
    tick_en <= 1'b1;
    bus(1'b1, 12'h220, 32'h0012_3400);
    base = tick_cnt;
    wait_ticks(20);
    bus(1'b0, 12'h200, 32'h0);
    chk(32'(rd_v[6]), 32'h1);
    // seconds clock on the pin must flip at the half second
    cw(2'h2, 32'h81);
    repeat (2) @(negedge SYS_CLK);
    pin0 = OUT_PIN_O;
    @(posedge SYS_CLK);
    wait_ticks(16400);
    @(negedge SYS_CLK);
    chk(32'(OUT_PIN_O), 32'(!pin0));
    @(posedge SYS_CLK);
    bus(1'b0, 12'h200, 32'h0);
    chk(32'(rd_v[2:1]), 32'h1);
    wait_ticks(32750);
    bus(1'b0, 12'h200, 32'h0);
    chk(32'(rd_v[2:1]), 32'h3);
    bus(1'b1, 12'h220, 32'h0012_3500);
    bus(1'b0, 12'h200, 32'h0);
    chk(32'(rd_v[1]), 32'h0);
    tick_en <= 1'b0;
    repeat (40) @(posedge SYS_CLK);
    bus(1'b0, 12'h200, 32'h0);
    chk(32'(rd_v[6]), 32'h0);
    $display("test timebase done");
    cw(2'h2, 32'h2000);
    SYS_IDLE <= 1'b1;
    repeat (3) @(negedge SYS_CLK);
    chk(32'(BUS_CLK_GATED), 32'h1);
    @(posedge SYS_CLK);
    bus(1'b1, 12'h204, 32'h2000);
    bus(1'b0, 12'h200, 32'h0);
    chk(rd_v, 32'h0);
    SYS_IDLE <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
    cchk();
    $display("test idle done");
    conclude();
  end
endmodule // testbench
